// ### hw/gpc_top.sv
// The APB slave port and the placing of the registers were decided locally.
`timescale 1ns/1ns
// Overview of operation
// - Eight pins, each input, push-pull or open-drain output, each with interrupt.
// - Reset clears all direction bits; pins start as inputs.
// - Reset clears all per-pin interrupt enables.
// - Reset clears polarity bits; interrupts trigger on low level.
// - Lowest six pins selectable as lamp outputs; reset default from straps.
// - Driver type bit picks push-pull or open-drain for outputs.
// - Open-drain drives low for data 0, releases pin for data 1.
// - Push-pull drives the pin to its data bit.
// - Input pins read back their synchronised pin level.
// - Output pins disable input buffer; pull-up stays on in general mode.
// - Per-pin status bit and enable bit; both needed for enabled interrupt.
// - Enabled statuses combine into one summary request and status bit.
// - Active levels over 40 ns are recognised; sources hold them longer.
// - Polarity set: high level sets the status bit.
// - Polarity clear: low level sets the status bit.
// - Lamp pins disable general input buffer and pull-up.
module gpc_top
  import gpc_pkg::*;
(
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [11:0]           paddr,
  input  wire logic [31:0]           pwdata,
  input  wire logic [3:0]            pstrb,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire logic [GPC_PINS-1:0]   pin_in,
  output logic      [GPC_PINS-1:0]   pin_out,
  output logic      [GPC_PINS-1:0]   pin_oe,
  output logic      [GPC_PINS-1:0]   pin_ibuf_en,
  output logic      [GPC_PINS-1:0]   pin_pullup_en,
  input  wire logic [GPC_LAMPS-1:0]  lamp_enable_straps,
  input  wire logic [GPC_LAMPS-1:0]  lamp_drive,
  output logic                       pin_irq_req
);
  import gpc_pkg::*;

  logic [GPC_PINS-1:0]  pin_direction_bits_ff;
  logic [GPC_PINS-1:0]  pin_level_polarity_bits_ff;
  logic [GPC_PINS-1:0]  pin_driver_type_bits_ff;
  logic [GPC_PINS-1:0]  pin_data_bits_ff;
  logic [GPC_PINS-1:0]  irq_en_ff;
  logic [GPC_PINS-1:0]  irq_sts_ff;
  logic [GPC_LAMPS-1:0] lamp_enable_bits_ff;
  logic                 strap_taken_ff;
  logic [GPC_PINS-1:0]  sync1_ff;
  logic [GPC_PINS-1:0]  sync2_ff;
  logic [GPC_PINS-1:0]  lamp_mask;
  logic [GPC_PINS-1:0]  lamp_drive_pins;
  logic [GPC_PINS-1:0]  active_lvl;
  logic                 wr_acc;
  logic                 rd_acc;
  logic [31:0]          nxt_prdata;
  logic                 addr_ok;

  function automatic logic [7:0] byte_merge(input logic [7:0] old, input logic [7:0] nw, input logic en);
    byte_merge = en ? nw : old;
  endfunction

  // Writes land on the edge that samples pready high, as the master expects
  assign wr_acc    = psel && penable && pwrite && pready;
  assign rd_acc    = psel && penable && !pwrite && !pready;
  assign lamp_mask = {{(GPC_PINS-GPC_LAMPS){1'b0}}, lamp_enable_bits_ff};
  assign lamp_drive_pins = {{(GPC_PINS-GPC_LAMPS){1'b0}}, lamp_drive};
  assign addr_ok   = (paddr == GPC_ADDR_DATA) || (paddr == GPC_ADDR_CFG) || (paddr == GPC_ADDR_IRQ) ||
                     (paddr == GPC_ADDR_LAMP) || (paddr == GPC_ADDR_SYS);

  // Two flops before anything reads the pins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_ff <= GPC_RST8;
      sync2_ff <= GPC_RST8;
    end else begin
      sync1_ff <= pin_in;
      sync2_ff <= sync1_ff;
    end
  end

  // Data, direction word: data in low byte, direction in next byte
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_direction_bits_ff <= GPC_RST8;
      pin_data_bits_ff      <= GPC_RST8;
    end else if (wr_acc && paddr == GPC_ADDR_DATA) begin
      pin_data_bits_ff      <= byte_merge(pin_data_bits_ff, pwdata[GPC_F_LO +: GPC_PINS], pstrb[0]);
      pin_direction_bits_ff <= byte_merge(pin_direction_bits_ff, pwdata[GPC_F_HI +: GPC_PINS], pstrb[1]);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_driver_type_bits_ff    <= GPC_RST8;
      pin_level_polarity_bits_ff <= GPC_RST8;
    end else if (wr_acc && paddr == GPC_ADDR_CFG) begin
      pin_driver_type_bits_ff    <= byte_merge(pin_driver_type_bits_ff, pwdata[GPC_F_LO +: GPC_PINS], pstrb[0]);
      pin_level_polarity_bits_ff <= byte_merge(pin_level_polarity_bits_ff, pwdata[GPC_F_HI +: GPC_PINS], pstrb[1]);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_en_ff <= GPC_RST8;
    end else if (wr_acc && paddr == GPC_ADDR_IRQ && pstrb[1]) begin
      irq_en_ff <= pwdata[GPC_F_HI +: GPC_PINS];
    end
  end

  // Strap caught on the first clock after reset release, not in reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lamp_enable_bits_ff <= {GPC_LAMPS{1'b0}};
      strap_taken_ff      <= 1'b0;
    end else if (!strap_taken_ff) begin
      lamp_enable_bits_ff <= lamp_enable_straps;
      strap_taken_ff      <= 1'b1;
    end else if (wr_acc && paddr == GPC_ADDR_LAMP && pstrb[0]) begin
      lamp_enable_bits_ff <= pwdata[GPC_LAMPS-1:0];
    end
  end

  // Synchroniser plus register adds three cycles (30 ns) of latency, below the 40 ns minimum
  assign active_lvl = ~(sync2_ff ^ pin_level_polarity_bits_ff) & ~lamp_mask;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_sts_ff <= GPC_RST8;
    end else begin
      // Set wins over write-one clear
      if (wr_acc && paddr == GPC_ADDR_IRQ && pstrb[0]) begin
        irq_sts_ff <= (irq_sts_ff & ~pwdata[GPC_F_LO +: GPC_PINS]) | active_lvl;
      end else begin
        irq_sts_ff <= irq_sts_ff | active_lvl;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_irq_req <= 1'b0;
    end else begin
      pin_irq_req <= |(irq_sts_ff & irq_en_ff);
    end
  end

  // Pin drivers; lamp pins follow the lamp source as push-pull
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_out       <= GPC_RST8;
      pin_oe        <= GPC_RST8;
      pin_ibuf_en   <= {GPC_PINS{1'b1}};
      pin_pullup_en <= {GPC_PINS{1'b1}};
    end else begin
      for (int i = 0; i < GPC_PINS; i++) begin
        if (lamp_mask[i]) begin
          pin_out[i]       <= lamp_drive_pins[i];
          pin_oe[i]        <= 1'b1;
          pin_ibuf_en[i]   <= 1'b0;
          pin_pullup_en[i] <= 1'b0;
        end else if (pin_direction_bits_ff[i]) begin
          if (pin_driver_type_bits_ff[i]) begin
            pin_out[i] <= pin_data_bits_ff[i];
            pin_oe[i]  <= 1'b1;
          end else begin
            pin_out[i] <= 1'b0;
            pin_oe[i]  <= !pin_data_bits_ff[i];
          end
          pin_ibuf_en[i]   <= 1'b0;
          pin_pullup_en[i] <= 1'b1;
        end else begin
          pin_out[i]       <= 1'b0;
          pin_oe[i]        <= 1'b0;
          pin_ibuf_en[i]   <= 1'b1;
          pin_pullup_en[i] <= 1'b1;
        end
      end
    end
  end

  always_comb begin
    nxt_prdata = 32'h0000_0000;
    unique case (paddr)
      GPC_ADDR_DATA: begin
        for (int i = 0; i < GPC_PINS; i++) begin
          nxt_prdata[GPC_F_LO+i] = pin_direction_bits_ff[i] ? pin_data_bits_ff[i] : sync2_ff[i];
        end
        nxt_prdata[GPC_F_HI +: GPC_PINS] = pin_direction_bits_ff;
      end
      GPC_ADDR_CFG: begin
        nxt_prdata[GPC_F_LO +: GPC_PINS] = pin_driver_type_bits_ff;
        nxt_prdata[GPC_F_HI +: GPC_PINS] = pin_level_polarity_bits_ff;
      end
      GPC_ADDR_IRQ: begin
        nxt_prdata[GPC_F_LO +: GPC_PINS] = irq_sts_ff;
        nxt_prdata[GPC_F_HI +: GPC_PINS] = irq_en_ff;
      end
      GPC_ADDR_LAMP: begin
        nxt_prdata[GPC_LAMPS-1:0] = lamp_enable_bits_ff;
      end
      GPC_ADDR_SYS: begin
        nxt_prdata[0] = pin_irq_req;
      end
      default: begin
        nxt_prdata = 32'h0000_0000;
      end
    endcase
  end

  // One wait state: answer registered in the cycle after access entry
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !addr_ok;
      if (rd_acc) begin
        prdata <= nxt_prdata;
      end
    end
  end

  a_od_release: assert property (@(posedge pclk) disable iff (!presetn)
    (pin_direction_bits_ff[0] && !pin_driver_type_bits_ff[0] && !lamp_mask[0] && pin_data_bits_ff[0])
    |=> !pin_oe[0])
    else $error("open drain pin driven while data is one");
  a_od_low: assert property (@(posedge pclk) disable iff (!presetn)
    (pin_direction_bits_ff[1] && !pin_driver_type_bits_ff[1] && !lamp_mask[1] && !pin_data_bits_ff[1])
    |=> (pin_oe[1] && !pin_out[1]))
    else $error("open drain pin not pulled low");
  a_pp_drive: assert property (@(posedge pclk) disable iff (!presetn)
    (pin_direction_bits_ff[2] && pin_driver_type_bits_ff[2] && !lamp_mask[2])
    |=> (pin_oe[2] && pin_out[2] == $past(pin_data_bits_ff[2])))
    else $error("push pull value wrong");
  a_input_float: assert property (@(posedge pclk) disable iff (!presetn)
    (!pin_direction_bits_ff[7])
    |=> (!pin_oe[7] && pin_ibuf_en[7]))
    else $error("input pin driven");
  a_lamp_buffers: assert property (@(posedge pclk) disable iff (!presetn)
    lamp_mask[3]
    |=> (!pin_ibuf_en[3] && !pin_pullup_en[3]))
    else $error("lamp pin buffers on");

  // Synchroniser holds its reset value for one edge, so skip that edge
  sequence s_high_held;
    ($past(presetn) && sync2_ff[4] && pin_level_polarity_bits_ff[4] && !lamp_mask[4]);
  endsequence

  a_high_sets: assert property (@(posedge pclk) disable iff (!presetn)
    s_high_held
    |=> irq_sts_ff[4])
    else $error("high level did not set status");
  a_low_sets: assert property (@(posedge pclk) disable iff (!presetn)
    ($past(presetn) && !sync2_ff[5] && !pin_level_polarity_bits_ff[5] && !lamp_mask[5])
    |=> irq_sts_ff[5])
    else $error("low level did not set status");
  a_sts_sticky: assert property (@(posedge pclk) disable iff (!presetn)
    (irq_sts_ff[6] && !(wr_acc && paddr == GPC_ADDR_IRQ && pstrb[0] && pwdata[6]))
    |=> irq_sts_ff[6])
    else $error("status bit lost without clear");
  a_summary: assert property (@(posedge pclk) disable iff (!presetn)
    1'b1
    |=> pin_irq_req == $past(|(irq_sts_ff & irq_en_ff)))
    else $error("summary request wrong");
  a_pin_sync: assert property (@(posedge pclk) disable iff (!presetn)
    ($past(presetn) && $past(presetn, 2))
    |-> sync2_ff == $past(pin_in, 2))
    else $error("synchroniser depth wrong");
  a_dir_reset: assert property (@(posedge pclk) disable iff (!presetn)
    !$past(presetn)
    |-> pin_direction_bits_ff == GPC_RST8)
    else $error("direction bits not cleared by reset");
  a_en_reset: assert property (@(posedge pclk) disable iff (!presetn)
    !$past(presetn)
    |-> irq_en_ff == GPC_RST8)
    else $error("interrupt enables not cleared by reset");
  a_pol_reset: assert property (@(posedge pclk) disable iff (!presetn)
    !$past(presetn)
    |-> pin_level_polarity_bits_ff == GPC_RST8)
    else $error("polarity bits not cleared by reset");
  a_lamp_strap: assert property (@(posedge pclk) disable iff (!presetn)
    (presetn && !strap_taken_ff)
    |=> lamp_enable_bits_ff == $past(lamp_enable_straps))
    else $error("lamp enables not taken from straps");
  a_lamp_drive: assert property (@(posedge pclk) disable iff (!presetn)
    lamp_mask[0]
    |=> (pin_oe[0] && pin_out[0] == $past(lamp_drive[0])))
    else $error("lamp pin not driven from lamp source");
  a_od_vector: assert property (@(posedge pclk) disable iff (!presetn)
    1'b1
    |=> (pin_oe & $past(pin_direction_bits_ff & ~pin_driver_type_bits_ff & ~lamp_mask & pin_data_bits_ff)) == GPC_RST8)
    else $error("open drain pin driven high");
  a_pp_vector: assert property (@(posedge pclk) disable iff (!presetn)
    1'b1
    |=> ((pin_out ^ $past(pin_data_bits_ff)) & $past(pin_direction_bits_ff & pin_driver_type_bits_ff & ~lamp_mask)) == GPC_RST8)
    else $error("push pull pin differs from data");
  a_out_ibuf: assert property (@(posedge pclk) disable iff (!presetn)
    1'b1
    |=> (pin_ibuf_en & $past(pin_direction_bits_ff | lamp_mask)) == GPC_RST8)
    else $error("input buffer on for driven pin");
  a_pullup_on: assert property (@(posedge pclk) disable iff (!presetn)
    1'b1
    |=> (~pin_pullup_en & ~$past(lamp_mask)) == GPC_RST8)
    else $error("pull-up off on general pin");
  a_read_data: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_acc && paddr == GPC_ADDR_DATA)
    |=> prdata[GPC_F_LO +: GPC_PINS] == $past((pin_direction_bits_ff & pin_data_bits_ff) | (~pin_direction_bits_ff & sync2_ff)))
    else $error("data read does not show pin level");
  a_sts_read: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_acc && paddr == GPC_ADDR_IRQ)
    |=> prdata[GPC_F_LO +: GPC_PINS] == $past(irq_sts_ff))
    else $error("status read wrong");
  a_sys_read: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_acc && paddr == GPC_ADDR_SYS)
    |=> prdata[0] == $past(pin_irq_req))
    else $error("summary bit read wrong");
  a_en_gate: assert property (@(posedge pclk) disable iff (!presetn)
    (irq_en_ff == GPC_RST8)
    |=> !pin_irq_req)
    else $error("request raised with no enable");

  sequence s_clear6;
    (wr_acc && paddr == GPC_ADDR_IRQ && pstrb[0] && pwdata[6]);
  endsequence

  a_sts_clear: assert property (@(posedge pclk) disable iff (!presetn)
    (s_clear6 ##0 !active_lvl[6])
    |=> !irq_sts_ff[6])
    else $error("write one did not clear status");

  // Four cycles of 10 ns cover the 40 ns minimum level
  sequence s_lvl_held;
    (pin_in[6] == pin_level_polarity_bits_ff[6] && !lamp_mask[6])[*4];
  endsequence

  a_level_caught: assert property (@(posedge pclk) disable iff (!presetn)
    s_lvl_held
    |-> ##[1:3] irq_sts_ff[6])
    else $error("held level not recognised");
endmodule

// ### inc/gpc_pkg.sv
package gpc_pkg;
  localparam int          GPC_PINS      = 8;
  localparam int          GPC_LAMPS     = 6;
  localparam logic [11:0] GPC_ADDR_DATA = 12'h000;
  localparam logic [11:0] GPC_ADDR_CFG  = 12'h004;
  localparam logic [11:0] GPC_ADDR_IRQ  = 12'h008;
  localparam logic [11:0] GPC_ADDR_LAMP = 12'h00C;
  localparam logic [11:0] GPC_ADDR_SYS  = 12'h010;
  // Field positions inside a word, each field 8 bits wide
  localparam int          GPC_F_LO      = 0;
  localparam int          GPC_F_HI      = 8;
  localparam logic [7:0]  GPC_RST8      = 8'h00;
  // Active level must last over this; 40 ns at 10 ns per cycle
  localparam int          GPC_LVL_NS    = 40;
  localparam int          GPC_CLK_NS    = 10;
  localparam int          GPC_LVL_CYC   = GPC_LVL_NS / GPC_CLK_NS;
endpackage

// ### testbench/gpc_pin_model.sv
`timescale 1ns/1ns
module gpc_pin_model (
  input  wire logic       pclk,
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe,
  input  wire logic [7:0] pin_pullup_en,
  input  wire logic [7:0] ext_en,
  input  wire logic [7:0] ext_val,
  output logic      [7:0] pin_in
);
  logic [7:0] noise_ff = 8'h00;
  // Undriven pin without pull-up keeps changing, never a stable guess
  always @(posedge pclk) begin
    noise_ff <= ~noise_ff;
  end
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pin_in[i] = pin_oe[i] ? pin_out[i] : ext_en[i] ? ext_val[i] : pin_pullup_en[i] | noise_ff[i];
    end
  end
endmodule

// ### testbench/tb_general_purpose_pin_controller.sv
`timescale 1ns/1ns
module tb_general_purpose_pin_controller;
  import gpc_pkg::*;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0]  pstrb = 4'hF;
  logic [31:0] prdata;
  logic        pready, pslverr, pin_irq_req;
  logic [7:0]  pin_in, pin_out, pin_oe, pin_ibuf_en, pin_pullup_en;
  logic [7:0]  ext_en = 8'h00, ext_val = 8'h00, d, v, p, a;
  logic [5:0]  lamp_enable_straps = 6'h00, lamp_drive = 6'h00;
  logic [33:0] exq[$];
  logic [33:0] e;
  int          bad_count = 0;
  int          checked = 0;

  always #5 pclk = ~pclk;

  gpc_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
    .pslverr, .pin_in, .pin_out, .pin_oe, .pin_ibuf_en, .pin_pullup_en, .lamp_enable_straps,
    .lamp_drive, .pin_irq_req);
  gpc_pin_model pins (.pclk, .pin_out, .pin_oe, .pin_pullup_en, .ext_en, .ext_val, .pin_in);

  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: bus got %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: pins got %h, expected %h", $time, got, exp);
    end
  endtask

  // Starts one edge late so back-to-back calls never touch psel twice in a step
  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] wd, input logic [31:0] exp,
                     input logic err);
    @(posedge pclk);
    exq.push_back({w, err, exp});
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= ad;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1) begin
      e = exq.pop_front();
      chk32({31'h0, pslverr}, {31'h0, e[32]});
      if (!e[33]) chk32(prdata, e[31:0]);
    end
  end

  task automatic print_verdict();
    if (bad_count == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    #100000;
    bad_count++;
    print_verdict();
  end

  initial begin
    void'($urandom(38));
    lamp_enable_straps = 6'($urandom());
    lamp_drive = 6'($urandom());
    d = 8'($urandom());
    v = 8'($urandom());
    p = 8'($urandom());
    v[0] = p[0];
    a = ~(v ^ p);
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, GPC_ADDR_LAMP, 0, {26'h0, lamp_enable_straps}, 1'b0);
    apb(1'b1, GPC_ADDR_LAMP, 0, 0, 1'b0);
    repeat (4) @(posedge pclk);
    apb(1'b0, GPC_ADDR_CFG, 0, 0, 1'b0);
    apb(1'b0, GPC_ADDR_DATA, 0, 32'h000000FF, 1'b0);
    apb(1'b1, GPC_ADDR_IRQ, 32'hFF, 0, 1'b0);
    apb(1'b0, GPC_ADDR_IRQ, 0, 0, 1'b0);
    apb(1'b0, 12'h014, 0, 0, 1'b1);
    apb(1'b1, 12'h014, 32'hFFFF, 0, 1'b1);
    apb(1'b1, GPC_ADDR_DATA, {16'h0, 8'hFF, d}, 0, 1'b0);
    apb(1'b1, GPC_ADDR_CFG, 32'hFF, 0, 1'b0);
    repeat (2) @(posedge pclk);
    chk8(pin_oe, 8'hFF);
    chk8(pin_out, d);
    chk8(pin_ibuf_en, 8'h00);
    chk8(pin_pullup_en, 8'hFF);
    apb(1'b0, GPC_ADDR_DATA, 0, {16'h0, 8'hFF, d}, 1'b0);
    apb(1'b1, GPC_ADDR_CFG, 0, 0, 1'b0);
    repeat (2) @(posedge pclk);
    chk8(pin_oe, ~d);
    chk8(pin_out & pin_oe, 8'h00);
    apb(1'b1, GPC_ADDR_LAMP, 32'h3F, 0, 1'b0);
    repeat (2) @(posedge pclk);
    chk8({2'b00, pin_out[5:0]}, {2'b00, lamp_drive});
    chk8({2'b00, pin_ibuf_en[5:0] | pin_pullup_en[5:0]}, 8'h00);
    apb(1'b1, GPC_ADDR_LAMP, 0, 0, 1'b0);
    ext_val <= v;
    ext_en <= 8'hFF;
    apb(1'b1, GPC_ADDR_DATA, 0, 0, 1'b0);
    apb(1'b1, GPC_ADDR_CFG, {16'h0, p, 8'h00}, 0, 1'b0);
    apb(1'b0, GPC_ADDR_DATA, 0, {24'h0, v}, 1'b0);
    apb(1'b1, GPC_ADDR_IRQ, 32'hFF, 0, 1'b0);
    apb(1'b1, GPC_ADDR_IRQ, 32'hFF00, 0, 1'b0);
    apb(1'b0, GPC_ADDR_IRQ, 0, {16'h0, 8'hFF, a}, 1'b0);
    apb(1'b0, GPC_ADDR_SYS, 0, 32'h1, 1'b0);
    chk8({7'h0, pin_irq_req}, 8'h01);
    ext_val <= ~p;
    repeat (4) @(posedge pclk);
    apb(1'b0, GPC_ADDR_IRQ, 0, {16'h0, 8'hFF, a}, 1'b0);
    apb(1'b1, GPC_ADDR_IRQ, 0, 0, 1'b0);
    apb(1'b0, GPC_ADDR_SYS, 0, 0, 1'b0);
    chk8({7'h0, pin_irq_req}, 8'h00);
    apb(1'b1, GPC_ADDR_IRQ, 32'hFFFF, 0, 1'b0);
    apb(1'b0, GPC_ADDR_IRQ, 0, 32'h0000FF00, 1'b0);
    apb(1'b0, GPC_ADDR_SYS, 0, 0, 1'b0);
    print_verdict();
  end
endmodule
